// *** bsd_pkg.sv ***
// constants, codes and field offsets for the bulk-only command decoder
// assumes byte-wide endpoint streams and a block medium of fixed block size
package bsd_pkg;

	// ------------------------------------------------------------
	// wrappers
	// ------------------------------------------------------------
	localparam int          CBW_LEN  = 31;
	localparam int          CSW_LEN  = 13;
	localparam logic [31:0] CBW_SIG  = 32'h43425355;
	localparam logic [31:0] CSW_SIG  = 32'h54425355;
	localparam int          TAG_OFS  = 4;
	localparam int          DLEN_OFS = 8;
	localparam int          FLAG_OFS = 12;
	localparam int          CB_OFS   = 15;
	localparam int          DIR_BIT  = 7;

	localparam logic [7:0] CSW_GOOD  = 8'h00;
	localparam logic [7:0] CSW_FAIL  = 8'h01;
	localparam logic [7:0] CSW_PHASE = 8'h02;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_TUR        = 8'h00;
	localparam logic [7:0] OP_REQ_SENSE  = 8'h03;
	localparam logic [7:0] OP_INQUIRY    = 8'h12;
	localparam logic [7:0] OP_MODE_SENSE = 8'h1A;
	localparam logic [7:0] OP_START_STOP = 8'h1B;
	localparam logic [7:0] OP_MEDIUM_RM  = 8'h1E;
	localparam logic [7:0] OP_READ_CAP   = 8'h25;
	localparam logic [7:0] OP_READ10     = 8'h28;
	localparam logic [7:0] OP_WRITE10    = 8'h2A;
	localparam logic [7:0] OP_VERIFY10   = 8'h2F;

	// ------------------------------------------------------------
	// sense and response data
	// ------------------------------------------------------------
	localparam logic [7:0]  SENSE_CUR      = 8'h70;
	localparam logic [7:0]  SENSE_ADD_LEN  = 8'h0A;
	localparam logic [3:0]  SK_NONE        = 4'h0;
	localparam logic [3:0]  SK_NOT_READY   = 4'h2;
	localparam logic [3:0]  SK_ILLEGAL     = 4'h5;
	localparam logic [7:0]  ASC_NONE       = 8'h00;
	localparam logic [7:0]  ASC_NO_MEDIUM  = 8'h3A;
	localparam logic [7:0]  ASC_BAD_OP     = 8'h20;
	localparam logic [7:0]  ASCQ_NONE      = 8'h00;
	localparam logic [31:0] INQ_LEN        = 32'h24;
	localparam logic [31:0] CAP_LEN        = 32'h08;
	localparam logic [31:0] SENSE_LEN      = 32'h12;
	localparam logic [31:0] MODE_LEN       = 32'h04;
	localparam logic [7:0]  INQ_RMB        = 8'h80;
	localparam logic [7:0]  INQ_VERSION    = 8'h04;
	localparam logic [7:0]  INQ_FORMAT     = 8'h02;
	localparam logic [7:0]  INQ_ADD_LEN    = 8'h1F;
	localparam logic [7:0]  INQ_PAD        = 8'h20;
	localparam logic [7:0]  MODE_DATA_LEN  = 8'h03;
	localparam logic [7:0]  MEDIUM_TYPE    = 8'h00;
	localparam int          BLK_SHIFT      = 9;
	localparam logic [31:0] BLK_LEN        = 32'h200;
	localparam logic [31:0] CAP_SAT_LBA    = 32'h0FFFFFFF;

	// ------------------------------------------------------------
	// power conditions and buffering
	// ------------------------------------------------------------
	localparam logic [3:0] PC_START_VALID = 4'h0;
	localparam logic [3:0] PC_ACTIVE      = 4'h1;
	localparam logic [3:0] PC_IDLE        = 4'h2;
	localparam logic [3:0] PC_STANDBY     = 4'h3;
	localparam int         FIFO_W         = 8;
	localparam int         FIFO_DEPTH     = 8;

	typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_STANDBY, PWR_STOPPED} bsd_pwr_t;

endpackage

// *** bsd_strm_if.sv ***
// byte stream with valid and ready between decoder and its fifo
// assumes both ends share the decoder clock
interface bsd_strm_if;
	logic                       vld;
	logic                       rdy;
	logic [bsd_pkg::FIFO_W-1:0] dat;
	modport src (output vld, output dat, input rdy);
	modport snk (input vld, input dat, output rdy);
endinterface

// *** bsd_fifo.sv ***
// synchronous fifo, width and depth as parameters
// assumes one clock; full stalls the writer through rdy
module bsd_fifo import bsd_pkg::*; #(
	parameter int W = FIFO_W,
	parameter int D = FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// streams
	bsd_strm_if.snk  wr,
	bsd_strm_if.src  rd
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [0:D-1];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0]   cnt_ff;
	logic          do_wr;
	logic          do_rd;

	assign wr.rdy = (cnt_ff != (AW+1)'(D));
	assign rd.vld = (cnt_ff != '0);
	assign rd.dat = mem[rp_ff];
	assign do_wr  = wr.vld && wr.rdy;
	assign do_rd  = rd.vld && rd.rdy;

	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem[wp_ff] <= wr.dat;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_wr) begin
				wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
			end
			if (do_rd) begin
				rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
			end
			if (do_wr && !do_rd) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (do_rd && !do_wr) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

	fifo_fill_c: cover property (@(posedge core_clk) disable iff (rst) !wr.rdy);

endmodule // bsd_fifo

// *** bsd_decoder.sv ***
// bulk-only wrapper handling and command execution for a block medium
// assumes byte streams from the endpoint engine and a block-level medium port
module bsd_decoder import bsd_pkg::*; (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// bulk-out endpoint
	input  wire logic        bo_valid,
	input  wire logic [7:0]  bo_data,
	output logic             bo_ready,
	output logic             bo_ack,
	output logic             bo_stall,
	input  wire logic        reset_recovery,
	// bulk-in endpoint
	output logic             bi_valid,
	output logic [7:0]       bi_data,
	input  wire logic        bi_ready,
	// medium control
	input  wire logic        med_ready,
	input  wire logic [39:0] med_blocks,
	output logic             med_rd_start,
	output logic             med_wr_start,
	output logic [31:0]      med_lba,
	output logic [15:0]      med_count,
	output logic             med_load,
	output logic             med_eject,
	output bsd_pwr_t         pwr_state,
	// medium data
	input  wire logic        med_rd_valid,
	input  wire logic [7:0]  med_rd_data,
	output logic             med_rd_ready,
	output logic             med_wr_valid,
	output logic [7:0]       med_wr_data,
	input  wire logic        med_wr_ready
);
	typedef enum logic [2:0] {ST_CBW, ST_DEC, ST_DIN, ST_DOUT, ST_CSW, ST_STALL} bsd_state_t;

	bsd_state_t  state_ff;
	bsd_state_t  nxt_state;
	logic [7:0]  cbw_ff [0:CBW_LEN-1];
	logic [31:0] idx_ff;
	logic [31:0] xfer_ff;
	logic [31:0] residue_ff;
	logic [7:0]  status_ff;
	logic [3:0]  skey_ff;
	logic [7:0]  asc_ff;
	logic [7:0]  ascq_ff;
	logic        rd_ff;
	logic        wr_ff;
	logic        ack_ff;
	logic        rd_start_ff;
	logic        wr_start_ff;
	logic [31:0] lba_ff;
	logic [15:0] count_ff;
	logic        load_ff;
	logic        eject_ff;
	bsd_pwr_t    pwr_ff;
	logic        wv_ff;
	logic [7:0]  wd_ff;

	bsd_strm_if push_if ();
	bsd_strm_if pop_if ();

	// ------------------------------------------------------------
	// wrapper fields
	// ------------------------------------------------------------
	logic [7:0]  op;
	logic [31:0] tag;
	logic [31:0] dlen;
	logic        is_in;
	logic [31:0] cmd_lba;
	logic [15:0] cmd_cnt;
	logic [7:0]  cb4;
	logic        sig_ok;
	logic        bo_fire;
	logic        push_fire;
	logic        last_cbw;
	logic        dec;

	assign op      = cbw_ff[CB_OFS];
	assign tag     = {cbw_ff[TAG_OFS+3], cbw_ff[TAG_OFS+2], cbw_ff[TAG_OFS+1], cbw_ff[TAG_OFS]};
	assign dlen    = {cbw_ff[DLEN_OFS+3], cbw_ff[DLEN_OFS+2], cbw_ff[DLEN_OFS+1], cbw_ff[DLEN_OFS]};
	assign is_in   = cbw_ff[FLAG_OFS][DIR_BIT];
	assign cmd_lba = {cbw_ff[CB_OFS+2], cbw_ff[CB_OFS+3], cbw_ff[CB_OFS+4], cbw_ff[CB_OFS+5]};
	assign cmd_cnt = {cbw_ff[CB_OFS+7], cbw_ff[CB_OFS+8]};
	assign cb4     = cbw_ff[CB_OFS+4];
	assign sig_ok  = ({cbw_ff[3], cbw_ff[2], cbw_ff[1], cbw_ff[0]} == CBW_SIG);
	assign bo_fire   = bo_valid && bo_ready;
	assign push_fire = push_if.vld && push_if.rdy;
	assign last_cbw  = (state_ff == ST_CBW) && bo_fire && (idx_ff == CBW_LEN - 1);
	assign dec       = (state_ff == ST_DEC);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic [31:0] d_nat;
	logic [31:0] d_xfer;
	logic [31:0] d_go;
	logic        d_dir_in;
	logic        d_med;
	logic        d_known;
	logic        d_fail;
	logic        d_phase;

	always_comb begin
		d_nat    = 32'h0;
		d_dir_in = 1'b0;
		d_med    = 1'b0;
		d_known  = 1'b1;
		case (op)
			OP_INQUIRY: begin
				d_nat    = INQ_LEN;
				d_dir_in = 1'b1;
			end
			OP_READ_CAP: begin
				d_nat    = CAP_LEN;
				d_dir_in = 1'b1;
			end
			OP_REQ_SENSE: begin
				d_nat    = SENSE_LEN;
				d_dir_in = 1'b1;
			end
			OP_MODE_SENSE: begin
				d_nat    = MODE_LEN;
				d_dir_in = 1'b1;
			end
			OP_READ10: begin
				d_nat    = 32'(cmd_cnt) << BLK_SHIFT;
				d_dir_in = 1'b1;
				d_med    = 1'b1;
			end
			OP_WRITE10: begin
				d_nat = 32'(cmd_cnt) << BLK_SHIFT;
				d_med = 1'b1;
			end
			OP_VERIFY10: begin
				// byte check only swallows host data; nothing is compared
				d_nat = cbw_ff[CB_OFS+1][1] ? dlen : 32'h0;
				d_med = 1'b1;
			end
			OP_TUR, OP_MEDIUM_RM: begin
				d_med = 1'b1;
			end
			OP_START_STOP: begin
				d_med = 1'b0;
			end
			default: begin
				d_known = 1'b0;
			end
		endcase
		d_fail  = !d_known || (d_med && !med_ready);
		d_xfer  = d_fail ? 32'h0 : ((dlen < d_nat) ? dlen : d_nat);
		d_phase = (d_xfer != 32'h0) && (d_dir_in != is_in);
		d_go    = d_phase ? 32'h0 : d_xfer;
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_CBW: begin
				if (last_cbw) begin
					nxt_state = sig_ok ? ST_DEC : ST_STALL;
				end
			end
			ST_DEC: begin
				if (d_go == 32'h0) begin
					nxt_state = ST_CSW;
				end else begin
					nxt_state = is_in ? ST_DIN : ST_DOUT;
				end
			end
			ST_DIN: begin
				if (push_fire && (idx_ff == xfer_ff - 32'h1)) begin
					nxt_state = ST_CSW;
				end
			end
			ST_DOUT: begin
				if (bo_fire && (idx_ff == xfer_ff - 32'h1)) begin
					nxt_state = ST_CSW;
				end
			end
			ST_CSW: begin
				if (push_fire && (idx_ff == CSW_LEN - 1)) begin
					nxt_state = ST_CBW;
				end
			end
			ST_STALL: begin
				if (reset_recovery) begin
					nxt_state = ST_CBW;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_CBW;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			idx_ff <= 32'h0;
		end else if (nxt_state != state_ff) begin
			idx_ff <= 32'h0;
		end else if (bo_fire || push_fire) begin
			idx_ff <= idx_ff + 32'h1;
		end
	end

	for (genvar i = 0; i < CBW_LEN; i++) begin : g_cbw
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				cbw_ff[i] <= 8'h00;
			end else if ((state_ff == ST_CBW) && bo_fire && (idx_ff == i)) begin
				cbw_ff[i] <= bo_data;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= last_cbw && sig_ok;
		end
	end

	// ------------------------------------------------------------
	// outcome and sense
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			xfer_ff    <= 32'h0;
			residue_ff <= 32'h0;
			status_ff  <= CSW_GOOD;
			rd_ff      <= 1'b0;
			wr_ff      <= 1'b0;
		end else if (dec) begin
			xfer_ff    <= d_go;
			residue_ff <= dlen - d_go;
			status_ff  <= d_fail ? CSW_FAIL : (d_phase ? CSW_PHASE : CSW_GOOD);
			rd_ff      <= (op == OP_READ10);
			wr_ff      <= (op == OP_WRITE10);
		end
	end

	// set in decode and clear after request sense never meet in one cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			skey_ff <= SK_NONE;
			asc_ff  <= ASC_NONE;
			ascq_ff <= ASCQ_NONE;
		end else if (dec && d_fail) begin
			skey_ff <= d_known ? SK_NOT_READY : SK_ILLEGAL;
			asc_ff  <= d_known ? ASC_NO_MEDIUM : ASC_BAD_OP;
			ascq_ff <= ASCQ_NONE;
		end else if ((state_ff == ST_CSW) && (nxt_state == ST_CBW) && (op == OP_REQ_SENSE)) begin
			skey_ff <= SK_NONE;
			asc_ff  <= ASC_NONE;
			ascq_ff <= ASCQ_NONE;
		end
	end

	// ------------------------------------------------------------
	// medium control
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_start_ff <= 1'b0;
			wr_start_ff <= 1'b0;
			lba_ff      <= 32'h0;
			count_ff    <= 16'h0;
		end else begin
			rd_start_ff <= dec && (op == OP_READ10) && (d_go != 32'h0);
			wr_start_ff <= dec && (op == OP_WRITE10) && (d_go != 32'h0);
			if (dec) begin
				lba_ff   <= cmd_lba;
				count_ff <= cmd_cnt;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwr_ff   <= PWR_ACTIVE;
			load_ff  <= 1'b0;
			eject_ff <= 1'b0;
		end else begin
			load_ff  <= 1'b0;
			eject_ff <= 1'b0;
			if (dec && (op == OP_START_STOP)) begin
				if (cb4[7:4] != PC_START_VALID) begin
					if (cb4[7:4] == PC_ACTIVE) begin
						pwr_ff <= PWR_ACTIVE;
					end else if (cb4[7:4] == PC_IDLE) begin
						pwr_ff <= PWR_IDLE;
					end else if (cb4[7:4] == PC_STANDBY) begin
						pwr_ff <= PWR_STANDBY;
					end
				end else begin
					unique case ({cb4[0], cb4[1]})
						2'h0: pwr_ff <= PWR_STOPPED;
						2'h1: eject_ff <= 1'b1;
						2'h2: pwr_ff <= PWR_ACTIVE;
						2'h3: load_ff <= 1'b1;
					endcase
				end
			end
		end
	end

	// write data held one stage so the medium sees registered data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wv_ff <= 1'b0;
			wd_ff <= 8'h00;
		end else if ((state_ff == ST_DOUT) && wr_ff && bo_fire) begin
			wv_ff <= 1'b1;
			wd_ff <= bo_data;
		end else if (med_wr_ready) begin
			wv_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// response bytes
	// ------------------------------------------------------------
	logic [7:0]  resp_dat;
	logic [7:0]  csw_dat;
	logic [31:0] csw_word;
	logic [39:0] cap_last;
	logic [31:0] cap_lba;
	logic [31:0] cap_word;
	logic [5:0]  ri;

	assign cap_last = med_blocks - 40'h1;
	assign cap_lba  = (cap_last[39:32] != 8'h00) ? CAP_SAT_LBA : cap_last[31:0];
	assign cap_word = ri[2] ? BLK_LEN : cap_lba;
	assign ri       = idx_ff[5:0];

	always_comb begin
		resp_dat = 8'h00;
		case (op)
			OP_INQUIRY: begin
				case (ri)
					6'h01: resp_dat = INQ_RMB;
					6'h02: resp_dat = INQ_VERSION;
					6'h03: resp_dat = INQ_FORMAT;
					6'h04: resp_dat = INQ_ADD_LEN;
					default: resp_dat = (ri >= 6'h08) ? INQ_PAD : 8'h00;
				endcase
			end
			OP_READ_CAP: resp_dat = cap_word[{~ri[1:0], 3'h0} +: 8];
			OP_REQ_SENSE: begin
				case (ri)
					6'h00: resp_dat = SENSE_CUR;
					6'h02: resp_dat = {4'h0, skey_ff};
					6'h07: resp_dat = SENSE_ADD_LEN;
					6'h0C: resp_dat = asc_ff;
					6'h0D: resp_dat = ascq_ff;
					default: resp_dat = 8'h00;
				endcase
			end
			OP_MODE_SENSE: begin
				if (ri == 6'h00) begin
					resp_dat = MODE_DATA_LEN;
				end else if (ri == 6'h01) begin
					resp_dat = MEDIUM_TYPE;
				end
			end
			default: resp_dat = 8'h00;
		endcase
	end

	always_comb begin
		unique case (idx_ff[3:2])
			2'h0: csw_word = CSW_SIG;
			2'h1: csw_word = tag;
			2'h2: csw_word = residue_ff;
			2'h3: csw_word = {24'h0, status_ff};
		endcase
		csw_dat = csw_word[{idx_ff[1:0], 3'h0} +: 8];
	end

	// ------------------------------------------------------------
	// stream plumbing
	// ------------------------------------------------------------
	always_comb begin
		push_if.vld = 1'b0;
		push_if.dat = 8'h00;
		bo_ready    = 1'b0;
		if (state_ff == ST_DIN) begin
			push_if.vld = rd_ff ? med_rd_valid : 1'b1;
			push_if.dat = rd_ff ? med_rd_data : resp_dat;
		end else if (state_ff == ST_CSW) begin
			push_if.vld = 1'b1;
			push_if.dat = csw_dat;
		end else if (state_ff == ST_CBW) begin
			bo_ready = 1'b1;
		end else if (state_ff == ST_DOUT) begin
			bo_ready = wr_ff ? (!wv_ff || med_wr_ready) : 1'b1;
		end
	end

	bsd_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) i_bsd_fifo (
		.core_clk (core_clk),
		.rst      (rst),
		.wr       (push_if.snk),
		.rd       (pop_if.src)
	);

	assign pop_if.rdy   = bi_ready;
	assign bi_valid     = pop_if.vld;
	assign bi_data      = pop_if.dat;
	assign bo_ack       = ack_ff;
	assign bo_stall     = (state_ff == ST_STALL);
	assign med_rd_start = rd_start_ff;
	assign med_wr_start = wr_start_ff;
	assign med_lba      = lba_ff;
	assign med_count    = count_ff;
	assign med_load     = load_ff;
	assign med_eject    = eject_ff;
	assign pwr_state    = pwr_ff;
	assign med_rd_ready = (state_ff == ST_DIN) && rd_ff && push_if.rdy;
	assign med_wr_valid = wv_ff;
	assign med_wr_data  = wd_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb_clk @(posedge core_clk); endclocking
	default disable iff (rst);

	cbw_ack_a: assert property (last_cbw && sig_ok |=> bo_ack && dec)
		else $error("good wrapper not acknowledged");
	bad_sig_a: assert property (last_cbw && !sig_ok |=> bo_stall && !bo_ack [*2])
		else $error("bad signature not stalled");
	inq_go_a: assert property (dec && op == OP_INQUIRY && is_in && dlen >= INQ_LEN |=> state_ff == ST_DIN && xfer_ff == INQ_LEN)
		else $error("inquiry not answered");
	unsup_a: assert property (dec && !d_known |=> skey_ff == SK_ILLEGAL && asc_ff == ASC_BAD_OP && status_ff == CSW_FAIL)
		else $error("unsupported opcode sense wrong");
	tur_a: assert property (dec && op == OP_TUR && !med_ready |=> status_ff == CSW_FAIL && skey_ff == SK_NOT_READY)
		else $error("unready test unit ready not failed");
	rd_zero_a: assert property (dec && op == OP_READ10 && cmd_cnt == 16'h0 |=> !med_rd_start && state_ff == ST_CSW)
		else $error("zero count read started medium");
	csw_sig_a: assert property (state_ff == ST_CSW && idx_ff == 32'h0 |-> push_if.vld && push_if.dat == CSW_SIG[7:0])
		else $error("status wrapper signature wrong");
	residue_a: assert property (state_ff == ST_CSW |-> residue_ff <= dlen)
		else $error("residue above length");
	csw_end_a: assert property (state_ff == ST_CSW && push_fire && idx_ff == CSW_LEN - 1 |=> state_ff == ST_CBW && idx_ff == 32'h0)
		else $error("status wrapper length wrong");
	status_a: assert property (state_ff == ST_CSW && idx_ff == 32'hC |-> push_if.dat == status_ff)
		else $error("status byte wrong");

	read_c: cover property (dec && op == OP_READ10 ##1 state_ff == ST_DIN ##[1:600] state_ff == ST_CSW);
	write_c: cover property (dec && op == OP_WRITE10 ##1 state_ff == ST_DOUT ##[1:600] state_ff == ST_CSW);
	stall_c: cover property (bo_stall ##[1:20] state_ff == ST_CBW);

endmodule // bsd_decoder

// *** bsd_med_model.sv ***
// medium model: counting read bytes, write side with stalls
// assumes the decoder clock; blocks of 512 bytes
module bsd_med_model (
	// clock
	input  wire logic  core_clk,
	// medium data
	input  wire logic  med_rd_ready,
	output logic       med_rd_valid,
	output logic [7:0] med_rd_data,
	input  wire logic  med_wr_valid,
	output logic       med_wr_ready,
	output int         wr_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		med_rd_valid = 1'b1;
		med_rd_data = 8'h00;
		med_wr_ready = 1'b0;
		wr_seen = 0;
	end
	// ready toggles so the staging register must hold its byte
	always @(posedge core_clk) begin
		if (med_rd_ready)
			med_rd_data <= med_rd_data + 8'h01;
		if (med_wr_valid && med_wr_ready)
			wr_seen <= wr_seen + 1;
		med_wr_ready <= !med_wr_ready;
	end
endmodule // bsd_med_model

// *** bsd_decoder_test.sv ***
// bench: host tasks on both bulk endpoints, medium model beyond
// assumes decoder ports as declared and one clock
module bsd_decoder_test import bsd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst = 1'b1, bo_valid = 1'b0, reset_recovery = 1'b0;
	logic bi_ready = 1'b0, med_ready = 1'b0, hold = 1'b0;
	logic [7:0] bo_data = 8'h00;
	logic [39:0] med_blocks = 40'h10_0000_0000;
	logic bo_ready, bo_stall, bi_valid, med_rd_valid, med_rd_ready, med_wr_valid, med_wr_ready;
	logic [7:0] bi_data, med_rd_data, q[$];
	logic [31:0] tg;
	logic [7:0] ops[4] = '{OP_TUR, 8'hFF, OP_MEDIUM_RM, OP_VERIFY10};
	logic [11:0] ka[4] = '{12'h23A, 12'h520, 12'h23A, 12'h23A};
	logic [7:0] ss[6] = '{8'h03, 8'h01, 8'h00, 8'h02, 8'h13, 8'h30};
	int err_total = 0, compares = 0, wr_seen;
	int acks = 0, rds = 0, wrs = 0, lds = 0, ejs = 0, wbad = 0, a0;
	logic bo_ack, med_rd_start, med_wr_start, med_load, med_eject;
	logic [7:0] med_wr_data;
	logic [15:0] med_count;
	logic [31:0] med_lba;
	bsd_pwr_t pw;
	bsd_pwr_t ps[6] = '{PWR_ACTIVE, PWR_ACTIVE, PWR_STOPPED, PWR_STOPPED, PWR_ACTIVE, PWR_STANDBY};
	always #5 core_clk = ~core_clk;
	bsd_decoder i_bsd_decoder (.core_clk, .rst, .bo_valid, .bo_data, .bo_ready, .bo_ack, .bo_stall,
		.reset_recovery, .bi_valid, .bi_data, .bi_ready, .med_ready, .med_blocks, .med_rd_start,
		.med_wr_start, .med_lba, .med_count, .med_load, .med_eject, .pwr_state(pw),
		.med_rd_valid, .med_rd_data, .med_rd_ready, .med_wr_valid, .med_wr_data, .med_wr_ready);
	bsd_med_model i_bsd_med_model (.core_clk, .med_rd_ready, .med_rd_valid, .med_rd_data,
		.med_wr_valid, .med_wr_ready, .wr_seen);
	// ---
	// host side
	// ---
	always @(posedge core_clk) begin
		if (bi_valid && bi_ready)
			q.push_back(bi_data);
		bi_ready <= hold ? !bi_ready : 1'b1;
		// one-cycle pulses are counted so a later check cannot miss them
		if (bo_ack)
			acks++;
		if (med_rd_start)
			rds++;
		if (med_wr_start)
			wrs++;
		if (med_load)
			lds++;
		if (med_eject)
			ejs++;
		if (med_wr_valid && med_wr_ready && med_wr_data !== wr_seen[7:0])
			wbad++;
	end
	task ck(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task put(input logic [7:0] b);
		bo_valid <= 1'b1;
		bo_data <= b;
		do @(posedge core_clk); while (bo_ready !== 1'b1);
	endtask
	task cbw(input logic [31:0] len, input logic [7:0] fl, op, b4, input logic [15:0] cnt,
		input logic [31:0] bad = 32'h0, input logic [7:0] b1 = 8'h00);
		logic [247:0] w;
		tg = {16'h5A3C, fl, op};
		w = {56'h0, cnt[7:0], cnt[15:8], 16'h0, b4, 16'h0, b1, op, 8'h0A, 8'h00, fl, len, tg, CBW_SIG ^ bad};
		q.delete();
		for (int i = 0; i < CBW_LEN; i++)
			put(w[8*i+:8]);
		bo_valid <= 1'b0;
	endtask
	// a cycle passes first so bo_valid is never assigned twice in one step
	task dout(input int n);
		@(posedge core_clk);
		for (int i = 0; i < n; i++)
			put(i[7:0]);
		bo_valid <= 1'b0;
	endtask
	task fin(input int k, input logic [31:0] res, input logic [7:0] st);
		for (int t = 0; t < 3000 && q.size() < k + CSW_LEN; t++)
			@(posedge core_clk);
		ck("csw sig", CSW_SIG, {q[k+3], q[k+2], q[k+1], q[k]});
		ck("csw tag", tg, {q[k+7], q[k+6], q[k+5], q[k+4]});
		ck("residue", res, {q[k+11], q[k+10], q[k+9], q[k+8]});
		ck("status", st, q[k+12]);
		ck("length", 32'(k + CSW_LEN), 32'(q.size()));
	endtask
	task close_out;
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ---
	// tests
	// ---
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		cbw(36, 8'h80, OP_INQUIRY, 0, 0);
		fin(36, 0, CSW_GOOD);
		ck("inquiry", {8'h00, INQ_RMB, 16'h2020}, {q[0], q[1], q[24], q[35]});
		foreach (ops[i]) begin
			cbw(0, 0, ops[i], 0, 0);
			fin(0, 0, CSW_FAIL);
			cbw(18, 8'h80, OP_REQ_SENSE, 0, 0);
			fin(18, 0, CSW_GOOD);
			ck("sense", {SENSE_CUR, 4'h0, ka[i]}, {q[0], q[2], q[12]});
		end
		med_ready <= 1'b1;
		cbw(0, 0, OP_TUR, 0, 0);
		fin(0, 0, CSW_GOOD);
		cbw(0, 0, OP_MEDIUM_RM, 8'h01, 0);
		fin(0, 0, CSW_GOOD);
		foreach (ss[i]) begin
			cbw(0, 0, OP_START_STOP, ss[i], 0);
			fin(0, 0, CSW_GOOD);
			ck("power", ps[i], pw);
		end
		ck("load", 1, lds);
		ck("eject", 1, ejs);
		cbw(4, 8'h80, OP_MODE_SENSE, 0, 0);
		fin(4, 0, CSW_GOOD);
		ck("medium type", MEDIUM_TYPE, q[1]);
		cbw(8, 8'h80, OP_READ_CAP, 0, 0);
		fin(8, 0, CSW_GOOD);
		ck("last block", CAP_SAT_LBA, {q[0], q[1], q[2], q[3]});
		ck("block len", BLK_LEN, {q[4], q[5], q[6], q[7]});
		// host stalls bulk-in so the fifo fills
		hold <= 1'b1;
		cbw(512, 8'h80, OP_READ10, 8'h5A, 1);
		fin(512, 0, CSW_GOOD);
		ck("read data", 16'h00FF, {q[0], q[511]});
		ck("block addr", 32'h5A00, med_lba);
		ck("block count", 1, med_count);
		cbw(0, 8'h80, OP_READ10, 0, 0);
		fin(0, 0, CSW_GOOD);
		ck("read starts", 1, rds);
		cbw(512, 0, OP_WRITE10, 0, 1);
		dout(512);
		fin(0, 0, CSW_GOOD);
		ck("written", 512, 32'(wr_seen));
		ck("write data", 0, wbad);
		ck("write starts", 1, wrs);
		cbw(4, 0, OP_VERIFY10, 0, 0, 0, 8'h02);
		dout(4);
		fin(0, 0, CSW_GOOD);
		cbw(512, 0, OP_READ10, 0, 1);
		fin(0, 512, CSW_PHASE);
		a0 = acks;
		cbw(0, 0, OP_TUR, 0, 0, 32'h1);
		repeat (2) @(posedge core_clk);
		ck("stall", 1, bo_stall);
		ck("ack", a0, acks);
		reset_recovery <= 1'b1;
		@(posedge core_clk);
		reset_recovery <= 1'b0;
		@(posedge core_clk);
		ck("stall", 0, bo_stall);
		cbw(36, 8'h80, OP_INQUIRY, 0, 0);
		fin(36, 0, CSW_GOOD);
		ck("ack", a0 + 1, acks);
		close_out();
	end
	initial begin
		#200us;
		err_total++;
		close_out();
	end
endmodule // bsd_decoder_test
